// ===== rtl/dofs_pkg.sv
// Purpose: shared constants and types for the output fail-safe link
// Assumes: one 100 MHz clock on both ends
// Notes:   packets are abstracted to a word plus integrity flag
package dofs_pkg;
  localparam int unsigned DOFS_CHANNELS    = 32;
  localparam int unsigned DOFS_CODE_W      = 8;
  localparam int unsigned DOFS_CLK_MHZ     = 100;
  localparam int unsigned DOFS_CYCLE_US    = 5000;
  // exchange cycle in clocks, derived from the 5 ms period
  localparam int unsigned DOFS_CYCLE_CLKS  = DOFS_CYCLE_US * DOFS_CLK_MHZ;
  localparam int unsigned DOFS_LOSS_CYCLES = 3;
  localparam int unsigned DOFS_RESP_CLKS   = 16;
  localparam int unsigned DOFS_HB_CLKS     = 64;

  // error severity codes, higher value is more severe
  localparam logic [7:0] DOFS_ERR_NONE = 8'h00;
  localparam logic [7:0] DOFS_ERR_CHAN = 8'h10;
  localparam logic [7:0] DOFS_ERR_RESP = 8'h20;
  localparam logic [7:0] DOFS_ERR_COMM = 8'h30;
  localparam logic [7:0] DOFS_ERR_SEV  = 8'h40;

  typedef enum logic [1:0] {
    DOFS_RUN,
    DOFS_RUN_SAFE,
    DOFS_MODE_A,
    DOFS_UNPOWERED
  } dofs_mode_t;
endpackage

// ===== rtl/dofs_link_if.sv
// Purpose: link between the central logic module and the output module
// Assumes: same clock on both ends
// Notes:   one-cycle strobes carry each packet
`timescale 1ns/10ps
`default_nettype none
interface dofs_link_if;
  import dofs_pkg::*;
  // command direction
  logic                     cmd_vld;
  logic                     cmd_crc_ok;
  logic [DOFS_CHANNELS-1:0] cmd_data;
  logic                     trip_flag;
  // response direction
  logic                     rsp_vld;
  logic [DOFS_CHANNELS-1:0] rsp_chan_fail;
  logic                     rsp_safe_req;

  modport device (
    input  cmd_vld, cmd_crc_ok, cmd_data, trip_flag,
    output rsp_vld, rsp_chan_fail, rsp_safe_req
  );
  modport host (
    output cmd_vld, cmd_crc_ok, cmd_data, trip_flag,
    input  rsp_vld, rsp_chan_fail, rsp_safe_req
  );
endinterface
`default_nettype wire

// ===== rtl/dofs_output_module.sv
// Purpose: fail-safe control of the discrete_output_module
// Assumes: power_good and faults are synchronous to clk_i
// Notes:   open contact (0) is the safe value on every channel
// Summary of operation
// - open contact is safe; safe commands open
// - 32 channels, each commanded and forced alone
// - run mode processes, sends and receives
// - power loss forces unpowered mode, no function
// - flag output mismatch or slow conditioning
// - errors latch until power loss or worse
// - command loss: run-safe, request and open all
// - communication failure shows failure code
// - host trips all modules on lost responses
// - trip flag: request safe, open all channels
// - host may substitute safe values itself
// - supply or config memory fault cuts power except indication
// - after cut, mode_a with outputs tripped
// - severe fault stops heartbeat toggling
// - channel failure reported upstream with code
// - host commands failed channel safe
// - host detects lost module communication
`timescale 1ns/10ps
`default_nettype none
module dofs_output_module
  import dofs_pkg::*;
#(
  parameter int unsigned CHANNELS    = DOFS_CHANNELS,
  parameter int unsigned CYCLE_CLKS  = DOFS_CYCLE_CLKS,
  parameter int unsigned LOSS_CYCLES = DOFS_LOSS_CYCLES,
  parameter int unsigned RESP_CLKS   = DOFS_RESP_CLKS,
  parameter int unsigned HB_CLKS     = DOFS_HB_CLKS
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // link to central logic module
  dofs_link_if.device            link,
  // power and supervisor
  input  wire logic              power_good_i,
  input  wire logic              supply_fault_i,
  input  wire logic              config_mem_fault_i,
  input  wire logic              integrity_fault_i,
  output logic                   heartbeat_o,
  output logic                   unit_power_en_o,
  // output stage
  input  wire logic [CHANNELS-1:0] out_sense_i,
  input  wire logic [CHANNELS-1:0] chan_fail_i,
  output logic [CHANNELS-1:0]    out_drive_o,
  output logic                   safe_output_request_o,
  // indication board unit
  output logic [DOFS_CODE_W-1:0] fail_code_o,
  output dofs_mode_t             mode_o
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    dofs_mode_t                  mode;
    logic [31:0]                 cyc_cnt;
    logic [7:0]                  miss_cnt;
    logic                        got_pkt;
    logic [CHANNELS-1:0]         cmd;
    logic [CHANNELS-1:0]         drive;
    logic [15:0]                 resp_cnt;
    logic [15:0]                 hb_cnt;
    logic                        hb;
    logic                        sev;
    logic                        pwr_en;
    logic                        safe_output_request;
    logic [DOFS_CODE_W-1:0]      code;
    logic [CHANNELS-1:0]         cfail;
    logic                        rsp_vld;
  } dofs_dev_t;

  dofs_dev_t s_q;
  dofs_dev_t s_d;

  function automatic logic [DOFS_CODE_W-1:0] worse(input logic [DOFS_CODE_W-1:0] a,
                                                    input logic [DOFS_CODE_W-1:0] b);
    worse = (b > a) ? b : a;
  endfunction

  logic pkt_ok;
  logic cyc_end;
  logic mismatch;
  assign pkt_ok   = link.cmd_vld && link.cmd_crc_ok;
  assign cyc_end  = (s_q.cyc_cnt == 32'(CYCLE_CLKS - 1));
  assign mismatch = (s_q.drive != out_sense_i);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d         = s_q;
    s_d.rsp_vld = 1'b0;
    if (!power_good_i)
    begin
      s_d.mode   = DOFS_UNPOWERED;
      s_d.drive  = '0;
      s_d.safe_output_request    = 1'b1;
      s_d.code   = DOFS_ERR_NONE;
      s_d.sev    = 1'b0;
      s_d.pwr_en = 1'b0;
      s_d.cfail  = '0;
      s_d.miss_cnt = '0;
    end
    else if (s_q.mode == DOFS_UNPOWERED)
    begin
      s_d.mode   = DOFS_RUN;
      s_d.pwr_en = 1'b1;
      // a trip already standing must keep the request up on power return
      s_d.safe_output_request    = link.trip_flag;
      s_d.cyc_cnt = '0;
    end
    else
    begin
      if (pkt_ok)
      begin
        s_d.got_pkt = 1'b1;
        s_d.cmd     = link.cmd_data;
      end
      s_d.cyc_cnt = cyc_end ? '0 : s_q.cyc_cnt + 32'd1;
      if (cyc_end)
      begin
        s_d.got_pkt = pkt_ok;
        s_d.rsp_vld = 1'b1;
        if (s_q.got_pkt || pkt_ok)
          s_d.miss_cnt = '0;
        else if (s_q.miss_cnt < 8'(LOSS_CYCLES))
          s_d.miss_cnt = s_q.miss_cnt + 8'd1;
      end
      // conditioning response timer restarts only when the sensed output matches the drive, not when the drive changes
      if (mismatch)
      begin
        if (s_q.resp_cnt < 16'(RESP_CLKS))
          s_d.resp_cnt = s_q.resp_cnt + 16'd1;
        else
          s_d.code = worse(s_d.code, DOFS_ERR_RESP);
      end
      else
        s_d.resp_cnt = '0;
      if (s_q.drive != s_d.drive)
        s_d.resp_cnt = '0;
      if (|chan_fail_i)
      begin
        s_d.cfail = s_q.cfail | chan_fail_i;
        s_d.code  = worse(s_d.code, DOFS_ERR_CHAN);
      end
      if (integrity_fault_i)
      begin
        s_d.sev  = 1'b1;
        s_d.code = worse(s_d.code, DOFS_ERR_SEV);
      end
      if (supply_fault_i || config_mem_fault_i)
      begin
        s_d.pwr_en = 1'b0;
        s_d.mode   = DOFS_MODE_A;
        s_d.code   = worse(s_d.code, DOFS_ERR_SEV);
      end
      else if (s_q.mode == DOFS_RUN && s_d.miss_cnt >= 8'(LOSS_CYCLES))
      begin
        s_d.mode = DOFS_RUN_SAFE;
        s_d.code = worse(s_d.code, DOFS_ERR_COMM);
      end
      // heartbeat toggles only while no severe fault is latched and the mode is not mode_a
      if (!s_d.sev && s_d.mode != DOFS_MODE_A)
      begin
        if (s_q.hb_cnt == 16'(HB_CLKS - 1))
        begin
          s_d.hb_cnt = '0;
          s_d.hb     = ~s_q.hb;
        end
        else
          s_d.hb_cnt = s_q.hb_cnt + 16'd1;
      end
      // safe request plus per-channel open, redundantly
      s_d.safe_output_request = (s_d.mode != DOFS_RUN) || link.trip_flag;
      if (s_d.safe_output_request)
        s_d.drive = '0;
      else
        s_d.drive = s_d.cmd & ~s_d.cfail;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q          <= '0;
      s_q.mode     <= DOFS_UNPOWERED;
      s_q.safe_output_request      <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign out_drive_o           = s_q.drive;
  assign safe_output_request_o = s_q.safe_output_request;
  assign heartbeat_o           = s_q.hb;
  assign unit_power_en_o       = s_q.pwr_en;
  assign fail_code_o           = s_q.code;
  assign mode_o                = s_q.mode;
  assign link.rsp_vld          = s_q.rsp_vld;
  assign link.rsp_chan_fail    = s_q.cfail;
  assign link.rsp_safe_req     = s_q.safe_output_request;
endmodule
`default_nettype wire

// ===== rtl/dofs_logic_module.sv
// Purpose: central_logic_module end of the output link
// Assumes: application supplies commands once per exchange cycle
// Notes:   trip flag is broadcast while responses are missing
`timescale 1ns/10ps
`default_nettype none
module dofs_logic_module
  import dofs_pkg::*;
#(
  parameter int unsigned CHANNELS    = DOFS_CHANNELS,
  parameter int unsigned CYCLE_CLKS  = DOFS_CYCLE_CLKS,
  parameter int unsigned LOSS_CYCLES = DOFS_LOSS_CYCLES
)(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  // link to output module
  dofs_link_if.host                link,
  // application side
  input  wire logic [CHANNELS-1:0] app_cmd_i,
  output logic [CHANNELS-1:0]      app_chan_fail_o,
  output logic                     module_lost_o
);
  typedef struct packed {
    logic [31:0]         cyc_cnt;
    logic [7:0]          miss_cnt;
    logic                got_rsp;
    logic                cmd_vld;
    logic [CHANNELS-1:0] cmd;
    logic [CHANNELS-1:0] cfail;
    logic                lost;
  } dofs_host_t;

  dofs_host_t s_q;
  dofs_host_t s_d;
  logic       cyc_end;
  assign cyc_end = (s_q.cyc_cnt == 32'(CYCLE_CLKS - 1));

  always_comb
  begin
    s_d         = s_q;
    s_d.cmd_vld = 1'b0;
    s_d.cyc_cnt = cyc_end ? '0 : s_q.cyc_cnt + 32'd1;
    if (link.rsp_vld)
    begin
      s_d.got_rsp = 1'b1;
      s_d.cfail   = link.rsp_chan_fail;
    end
    if (cyc_end)
    begin
      s_d.cmd_vld = 1'b1;
      s_d.got_rsp = link.rsp_vld;
      if (s_q.got_rsp || link.rsp_vld)
        s_d.miss_cnt = '0;
      else if (s_q.miss_cnt < 8'(LOSS_CYCLES))
        s_d.miss_cnt = s_q.miss_cnt + 8'd1;
      s_d.lost = (s_d.miss_cnt >= 8'(LOSS_CYCLES));
      // failed channels and a lost module get safe values
      s_d.cmd = s_d.lost ? '0 : (app_cmd_i & ~s_d.cfail);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign link.cmd_vld     = s_q.cmd_vld;
  assign link.cmd_crc_ok  = s_q.cmd_vld;
  assign link.cmd_data    = s_q.cmd;
  assign link.trip_flag   = s_q.lost;
  assign app_chan_fail_o  = s_q.cfail;
  assign module_lost_o    = s_q.lost;
endmodule
`default_nettype wire

// ===== testbench/dofs_link_monitor.sv
// Purpose: interface checks on the link between two design ends
// Assumes: exchange cycle shortened to CYC clocks
// Notes:   watches only the link that joins the two design modules
`timescale 1ns/10ps
`default_nettype none
module dofs_link_monitor
  import dofs_pkg::*;
#(
  parameter int CYC = 20
)(
  // clock and reset
  input wire logic                     clk_i,
  input wire logic                     arst_n_i,
  // link signals
  input wire logic                     cmd_vld,
  input wire logic                     cmd_crc_ok,
  input wire logic [DOFS_CHANNELS-1:0] cmd_data,
  input wire logic                     trip_flag,
  input wire logic                     rsp_vld,
  input wire logic [DOFS_CHANNELS-1:0] rsp_chan_fail,
  input wire logic                     rsp_safe_req
);
  localparam logic [7:0] LOST = 8'h64;
  logic [7:0] sil_q;
  // clocks since the last response, saturating
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      sil_q <= 8'h00;
    else if (rsp_vld)
      sil_q <= 8'h00;
    else if (sil_q < LOST)
      sil_q <= sil_q + 8'h01;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  rsp_pulse_a: assert property (rsp_vld |=> !rsp_vld [*8])
    else $error("response strobe repeated too soon");
  cmd_space_a: assert property (cmd_vld |=> !cmd_vld [*8])
    else $error("command strobe repeated too soon");
  cmd_period_a: assert property (cmd_vld |-> ##[CYC:CYC] cmd_vld)
    else $error("command missing in next exchange cycle");
  cmd_integrity_a: assert property (cmd_vld |-> cmd_crc_ok)
    else $error("host sent a packet failing integrity");
  trip_safe_a: assert property (trip_flag |=> rsp_safe_req)
    else $error("trip flag did not raise safe request");
  trip_cause_a: assert property ($rose(trip_flag) |-> sil_q >= 8'h14)
    else $error("trip raised while responses arrive");
  trip_bound_a: assert property (sil_q == LOST |-> trip_flag)
    else $error("trip not raised after lost responses");
  trip_clear_a: assert property ($fell(trip_flag) |-> sil_q < 8'h14)
    else $error("trip dropped with no response");
  fail_latch_a: assert property (|(~rsp_chan_fail & $past(rsp_chan_fail)) |-> rsp_safe_req)
    else $error("failed channel status dropped");
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: end-to-end bench for the output fail-safe link
// Assumes: exchange cycle shortened to 20 clocks
// Notes:   second device is fed by the bench to break the link on purpose
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dofs_pkg::*;
  localparam int unsigned CYC = 20;
  typedef struct {int k; logic [31:0] v;} dofs_note_t;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, pwr = 1'b0, sup_f = 1'b0, int_f = 1'b0;
  logic        bad_s = 1'b0, cfg_f = 1'b0, sor1, sor2, pen, hb, lost;
  logic [31:0] cmd = '0, fail = '0, drv1, drv2, afail;
  logic [7:0]  code1, code2;
  dofs_mode_t  mode1, mode2;
  int          fails = 0, comparisons = 0;
  dofs_note_t  q[$];
  string       nm[13] = '{"drive", "sor", "code", "mode", "drive_far", "sor_far", "code_far",
                          "mode_far", "host_fail", "power_en", "module_lost", "heartbeat",
                          "host_cmd"};
  dofs_link_if l1 ();
  dofs_link_if l2 ();

  always #5 clk_i = ~clk_i;

  dofs_output_module #(.CYCLE_CLKS(CYC), .HB_CLKS(4), .RESP_CLKS(4)) i_dofs_output_module (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link(l1), .power_good_i(pwr), .supply_fault_i(sup_f),
    .config_mem_fault_i(cfg_f), .integrity_fault_i(int_f), .heartbeat_o(hb),
    .unit_power_en_o(pen), .out_sense_i(bad_s ? ~drv1 : drv1), .chan_fail_i(fail),
    .out_drive_o(drv1), .safe_output_request_o(sor1), .fail_code_o(code1), .mode_o(mode1));
  // far device: the bench plays a host that breaks the link
  dofs_output_module #(.CYCLE_CLKS(CYC), .HB_CLKS(4), .RESP_CLKS(4)) i_dofs_output_module_far (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link(l2), .power_good_i(pwr), .supply_fault_i(sup_f),
    .config_mem_fault_i(cfg_f), .integrity_fault_i(int_f), .heartbeat_o(), .unit_power_en_o(),
    .out_sense_i(drv2), .chan_fail_i(fail), .out_drive_o(drv2),
    .safe_output_request_o(sor2), .fail_code_o(code2), .mode_o(mode2));
  dofs_logic_module #(.CYCLE_CLKS(CYC)) i_dofs_logic_module (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .link(l1), .app_cmd_i(cmd), .app_chan_fail_o(afail),
    .module_lost_o(lost));
  dofs_link_monitor #(.CYC(CYC)) i_dofs_link_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .cmd_vld(l1.cmd_vld), .cmd_crc_ok(l1.cmd_crc_ok), .cmd_data(l1.cmd_data),
    .trip_flag(l1.trip_flag), .rsp_vld(l1.rsp_vld), .rsp_chan_fail(l1.rsp_chan_fail),
    .rsp_safe_req(l1.rsp_safe_req));

  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic note(int k, logic [31:0] v);
    q.push_back('{k, v});
  endtask

  function automatic logic [31:0] obs(int k);
    case (k)
      0: return drv1;
      1: return {31'h0, sor1};
      2: return {24'h0, code1};
      3: return {30'h0, mode1};
      4: return drv2;
      5: return {31'h0, sor2};
      6: return {24'h0, code2};
      7: return {30'h0, mode2};
      8: return afail;
      9: return {31'h0, pen};
      10: return {31'h0, lost};
      11: return {31'h0, hb};
      default: return l1.cmd_data;
    endcase
  endfunction

  // far host: one strobe, data inverted once released
  task automatic pkt(logic ok, logic [31:0] d);
    l2.cmd_vld <= 1'b1;
    l2.cmd_crc_ok <= ok;
    l2.cmd_data <= d;
    cyc(1);
    l2.cmd_vld <= 1'b0;
    l2.cmd_crc_ok <= 1'b0;
    l2.cmd_data <= ~d;
    cyc(CYC - 1);
  endtask

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(negedge clk_i)
    while (q.size() > 0)
    begin
      dofs_note_t n;
      n = q.pop_front();
      check(nm[n.k], obs(n.k), n.v);
    end

  initial
  begin
    cyc(3000);
    fails++;
    final_report();
  end

  initial
  begin
    logic h;
    l2.cmd_vld = 1'b0;
    l2.cmd_crc_ok = 1'b0;
    l2.cmd_data = 32'h0;
    l2.trip_flag = 1'b0;
    void'($urandom(32'h9950114B));
    cyc(2);
    arst_n_i <= 1'b1;
    cyc(1);
    note(3, DOFS_UNPOWERED); note(0, 32'h0); note(1, 32'h1); note(9, 32'h0);
    pwr <= 1'b1;
    cyc(2);
    note(3, DOFS_RUN); note(7, DOFS_RUN); note(9, 32'h1);
    $display("test power-up done");
    pkt(1'b1, 32'hA5A5_0F0F);
    note(4, 32'hA5A5_0F0F);
    pkt(1'b0, 32'hFFFF_FFFF);
    note(4, 32'hA5A5_0F0F);
    l2.trip_flag <= 1'b1;
    pkt(1'b1, 32'hFFFF_FFFF);
    note(4, 32'h0); note(5, 32'h1); note(7, DOFS_RUN);
    l2.trip_flag <= 1'b0;
    cyc(4 * CYC);
    note(7, DOFS_RUN_SAFE); note(5, 32'h1); note(4, 32'h0); note(6, DOFS_ERR_COMM);
    $display("test far link loss done");
    repeat (4)
    begin
      cmd <= $urandom();
      cyc(2 * CYC + 2);
      note(0, cmd); note(1, 32'h0);
    end
    $display("test commands done");
    fail <= 32'h1 << $urandom_range(31, 0);
    cmd <= 32'hFFFF_FFFF;
    cyc(3 * CYC);
    note(0, ~fail); note(8, fail); note(2, DOFS_ERR_CHAN);
    note(12, ~fail);
    bad_s <= 1'b1;
    cyc(8);
    note(2, DOFS_ERR_RESP);
    bad_s <= 1'b0;
    cyc(4);
    note(2, DOFS_ERR_RESP);
    int_f <= 1'b1;
    cyc(2);
    int_f <= 1'b0;
    cyc(2);
    // four clocks hold exactly one toggle of a healthy heartbeat
    @(negedge clk_i);
    h = hb;
    cyc(4);
    note(11, {31'h0, h});
    note(2, DOFS_ERR_SEV);
    $display("test faults done");
    sup_f <= 1'b1;
    cyc(2);
    note(3, DOFS_MODE_A); note(9, 32'h0); note(0, 32'h0); note(2, DOFS_ERR_SEV);
    pwr <= 1'b0;
    sup_f <= 1'b0;
    cyc(2);
    note(3, DOFS_UNPOWERED); note(2, DOFS_ERR_NONE);
    cyc(5 * CYC);
    note(10, 32'h1); note(12, 32'h0);
    pwr <= 1'b1;
    cyc(2);
    note(1, 32'h1);
    cfg_f <= 1'b1;
    cyc(2);
    note(3, DOFS_MODE_A); note(7, DOFS_MODE_A); note(9, 32'h0);
    $display("test power loss done");
    @(negedge clk_i);
    #1;
    final_report();
  end
endmodule
`default_nettype wire
